//--- logic/ocp_pkg.sv
// constants and types for the output compare and pwm unit
package ocp_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OCP_CONTROL_ONE_OFS = 8'h00;
  localparam logic [7:0] OCP_CONTROL_TWO_OFS = 8'h04;
  localparam logic [7:0] OCP_PRIMARY_OFS = 8'h08;
  localparam logic [7:0] OCP_SECONDARY_OFS = 8'h0c;
  localparam logic [7:0] OCP_STATUS_OFS = 8'h10;
  localparam logic [7:0] OCP_TIMER_OFS = 8'h14;

  // ****************************************
  // control_one fields
  // ****************************************
  localparam int OCP_MODE_LSB = 0;
  localparam int OCP_TRIG_MODE_BIT = 3;
  localparam int OCP_FAULT_EN_LSB = 4;
  localparam int OCP_CLK_SEL_LSB = 10;
  localparam logic [31:0] OCP_CONTROL_ONE_MASK = 32'h0000_1c7f;

  // ****************************************
  // control_two fields
  // ****************************************
  localparam int OCP_SYNC_SEL_LSB = 0;
  localparam int OCP_TRIG_SEL_BIT = 7;
  localparam int OCP_CASCADE_BIT = 8;
  localparam int OCP_TRISTATE_BIT = 9;
  localparam int OCP_INVERT_BIT = 10;
  localparam logic [31:0] OCP_CONTROL_TWO_MASK = 32'h0000_079f;
  localparam logic [31:0] OCP_CONTROL_TWO_RST = 32'h0000_001f;

  // status fields
  localparam int OCP_FLAG_BIT = 0;
  localparam int OCP_PIN_BIT = 1;
  localparam int OCP_FAULT_BIT = 2;
  localparam int OCP_ARMED_BIT = 3;

  // sync source meaning self
  localparam logic [4:0] OCP_SYNC_SELF = 5'h1f;

  // compare mode encodings
  localparam logic [2:0] OCP_MODE_OFF = 3'h0;
  localparam logic [2:0] OCP_MODE_SINGLE_HIGH = 3'h1;
  localparam logic [2:0] OCP_MODE_SINGLE_LOW = 3'h2;
  localparam logic [2:0] OCP_MODE_SINGLE_TOGGLE = 3'h3;
  localparam logic [2:0] OCP_MODE_DOUBLE_SHOT = 3'h4;
  localparam logic [2:0] OCP_MODE_DOUBLE_CONT = 3'h5;
  localparam logic [2:0] OCP_MODE_PWM_EDGE = 3'h6;
  localparam logic [2:0] OCP_MODE_PWM_CENTER = 3'h7;

  // clock source encodings
  localparam logic [2:0] OCP_CLK_SYSTEM = 3'h0;
  localparam logic [2:0] OCP_CLK_TIMER_A = 3'h1;
  localparam logic [2:0] OCP_CLK_TIMER_B = 3'h2;

  // ****************************************
  // one-shot arm states (gray along the path)
  // ****************************************
  typedef enum logic [1:0] {
    OCP_ST_IDLE = 2'b00,
    OCP_ST_RUN = 2'b01,
    OCP_ST_DONE = 2'b11
  } ocp_state_t;

endpackage : ocp_pkg

//--- logic/ocp_clk_sel.sv
// timebase tick selector for the output compare and pwm unit
`timescale 1ns/10ps
`default_nettype none
module ocp_clk_sel (
  input wire logic core_clk_in, // 25 mhz core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic [2:0] sel_in, // clock source select
  input wire logic tmr_a_pre_in, // timer a prescaler pin, async
  input wire logic tmr_b_pre_in, // timer b prescaler pin, async
  input wire logic ext_in, // other sources pin, async
  output logic tick_out // one-cycle timebase enable
);

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] prev;
    logic tick;
  } ocp_cs_t;

  ocp_cs_t q, d;

  // two-flop sync then rising edge detect on the second flop only
  always_comb begin
    d = q;
    d.s1 = {ext_in, tmr_b_pre_in, tmr_a_pre_in};
    d.s2 = q.s1;
    d.prev = q.s2;
    case (sel_in)
      ocp_pkg::OCP_CLK_SYSTEM: d.tick = 1'b1;
      ocp_pkg::OCP_CLK_TIMER_A: d.tick = q.s2[0] & ~q.prev[0];
      ocp_pkg::OCP_CLK_TIMER_B: d.tick = q.s2[1] & ~q.prev[1];
      default: d.tick = q.s2[2] & ~q.prev[2];
    endcase
  end

  // state register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_out = q.tick;

endmodule // ocp_clk_sel
`default_nettype wire

//--- logic/ocp_unit.sv
// output compare and pwm unit with apb register slave
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ocp_unit (
  input wire logic core_clk_in, // 25 mhz core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb write
  input wire logic [7:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic [3:0] pstrb_in, // apb byte strobes
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped
  input wire logic tmr_a_pre_in, // timer a prescaler output, async
  input wire logic tmr_b_pre_in, // timer b prescaler output, async
  input wire logic ext_clk_in, // alternate clock source, async
  input wire logic [2:0] fault_in, // fault pins, active high, async
  input wire logic [30:0] sync_in, // sync pulses of other modules
  input wire logic [15:0] peer_count_in, // even partner count, cascade
  input wire logic peer_wrap_in, // even partner wrap pulse
  output logic [15:0] count_out, // own timebase count
  output logic wrap_out, // own wrap pulse: period match or sync restart, the bottom turn in center mode
  output logic compare_output_out, // compare output pin level
  output logic compare_output_oe_out, // pin output enable
  output logic compare_interrupt_flag_out // sticky match flag
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    logic [31:0] control_one;
    logic [31:0] control_two;
    logic [15:0] primary;
    logic [15:0] secondary;
    logic [15:0] pri_shadow;
    logic [15:0] sec_shadow;
    logic [15:0] count;
    logic up;
    logic pin;
    logic flag;
    logic fault;
    logic triggered;
    logic wrap;
    logic [2:0] flt_s1;
    logic [2:0] flt_s2;
    logic [31:0] prdata;
    logic slverr;
    logic prdata_ready;
    ocp_pkg::ocp_state_t st;
  } ocp_st_t;

  ocp_st_t q, d;
  logic tick;

  // compare of two 16-bit values against the count, used four times
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction

  // maps a byte address to a register index, 7 is unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      ocp_pkg::OCP_CONTROL_ONE_OFS: reg_index = 3'h0;
      ocp_pkg::OCP_CONTROL_TWO_OFS: reg_index = 3'h1;
      ocp_pkg::OCP_PRIMARY_OFS: reg_index = 3'h2;
      ocp_pkg::OCP_SECONDARY_OFS: reg_index = 3'h3;
      ocp_pkg::OCP_STATUS_OFS: reg_index = 3'h4;
      ocp_pkg::OCP_TIMER_OFS: reg_index = 3'h5;
      default: reg_index = 3'h7;
    endcase
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r & mask;
  endfunction

  // ****************************************
  // clock source selection
  // ****************************************
  ocp_clk_sel u_clk_sel (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sel_in(q.control_one[ocp_pkg::OCP_CLK_SEL_LSB +: 3]),
    .tmr_a_pre_in(tmr_a_pre_in),
    .tmr_b_pre_in(tmr_b_pre_in),
    .ext_in(ext_clk_in),
    .tick_out(tick)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  logic [2:0] mode;
  logic [4:0] sync_sel;
  logic [2:0] flt_en;
  logic trig_sel, trig_mode, cascade, tristate, invert;
  logic acc, wr, rd, first;
  logic [2:0] idx;
  logic [31:0] pri_m, sec_m;
  logic sync_hit, period_hit, duty_hit, pwm, dbl, pri_hit, sec_hit;
  logic [15:0] eff_count;
  logic set_flag;

  // field decode from control registers
  always_comb begin
    mode = q.control_one[ocp_pkg::OCP_MODE_LSB +: 3];
    trig_mode = q.control_one[ocp_pkg::OCP_TRIG_MODE_BIT];
    flt_en = q.control_one[ocp_pkg::OCP_FAULT_EN_LSB +: 3];
    sync_sel = q.control_two[ocp_pkg::OCP_SYNC_SEL_LSB +: 5];
    trig_sel = q.control_two[ocp_pkg::OCP_TRIG_SEL_BIT];
    cascade = q.control_two[ocp_pkg::OCP_CASCADE_BIT];
    tristate = q.control_two[ocp_pkg::OCP_TRISTATE_BIT];
    invert = q.control_two[ocp_pkg::OCP_INVERT_BIT];
    pwm = (mode == ocp_pkg::OCP_MODE_PWM_EDGE) || (mode == ocp_pkg::OCP_MODE_PWM_CENTER);
    dbl = (mode == ocp_pkg::OCP_MODE_DOUBLE_SHOT) || (mode == ocp_pkg::OCP_MODE_DOUBLE_CONT);
    // in cascade the odd module compares the partner's count
    eff_count = cascade ? peer_count_in : q.count;
    // self sync restarts on own period match, else on the partner wrap in cascade or on the chosen pulse
    if (sync_sel == ocp_pkg::OCP_SYNC_SELF) begin
      sync_hit = 1'b0;
    end else if (cascade) begin
      sync_hit = peer_wrap_in;
    end else begin
      sync_hit = sync_in[sync_sel];
    end
    period_hit = hit(q.count, pwm ? q.sec_shadow : q.secondary);
    duty_hit = hit(eff_count, pwm ? q.pri_shadow : q.primary);
    pri_hit = tick && hit(eff_count, q.primary);
    sec_hit = tick && hit(eff_count, q.secondary);
    // one wait state: read data is captured in the first access cycle,
    // so a write lands only on the ready cycle and never twice
    acc = psel_in && penable_in;
    first = acc && !q.prdata_ready;
    wr = acc && pwrite_in && q.prdata_ready;
    rd = first && !pwrite_in;
    idx = reg_index(paddr_in);
    // 16-bit value registers merged as a word, upper half dropped
    pri_m = merge({16'h0000, q.primary}, pwdata_in, pstrb_in, 32'h0000_ffff);
    sec_m = merge({16'h0000, q.secondary}, pwdata_in, pstrb_in, 32'h0000_ffff);
  end

  // main behaviour
  always_comb begin
    d = q;
    d.wrap = 1'b0;
    d.prdata = q.prdata;
    d.slverr = 1'b0;
    d.prdata_ready = first;
    set_flag = 1'b0;
    // fault pins pass two flops before use
    d.flt_s1 = fault_in;
    d.flt_s2 = q.flt_s1;

    // timebase: runs while mode on and, in trigger mode, once triggered
    if (trig_sel && sync_hit) begin
      d.triggered = 1'b1;
    end
    if (mode != ocp_pkg::OCP_MODE_OFF && tick && (!trig_sel || q.triggered)) begin
      if (mode == ocp_pkg::OCP_MODE_PWM_CENTER) begin
        // center aligned counts up to period then back down
        if (q.up && period_hit) begin
          d.up = 1'b0;
          d.count = q.count - 16'h0001;
        end else if (!q.up && q.count == 16'h0000) begin
          d.up = 1'b1;
          d.count = 16'h0001;
          d.pri_shadow = q.primary;
          d.sec_shadow = q.secondary;
          d.wrap = 1'b1;
        end else begin
          d.count = q.up ? q.count + 16'h0001 : q.count - 16'h0001;
        end
      end else if (period_hit || (!trig_sel && sync_hit)) begin
        d.count = 16'h0000;
        d.wrap = 1'b1;
        d.pri_shadow = q.primary;
        d.sec_shadow = q.secondary;
        if (trig_sel && !trig_mode) begin
          d.triggered = 1'b0; // auto clear of trigger
        end
      end else begin
        d.count = q.count + 16'h0001;
      end
    end

    // output generation per mode
    case (mode)
      ocp_pkg::OCP_MODE_SINGLE_HIGH, ocp_pkg::OCP_MODE_SINGLE_LOW: begin
        if (q.st == ocp_pkg::OCP_ST_RUN && pri_hit) begin
          d.pin = (mode == ocp_pkg::OCP_MODE_SINGLE_HIGH);
          d.st = ocp_pkg::OCP_ST_DONE;
          set_flag = 1'b1;
        end
      end
      ocp_pkg::OCP_MODE_SINGLE_TOGGLE: begin
        if (pri_hit) begin
          d.pin = ~q.pin;
          set_flag = 1'b1;
        end
      end
      ocp_pkg::OCP_MODE_DOUBLE_SHOT, ocp_pkg::OCP_MODE_DOUBLE_CONT: begin
        if (q.st == ocp_pkg::OCP_ST_RUN && pri_hit) begin
          d.pin = 1'b1;
        end
        if (q.st == ocp_pkg::OCP_ST_RUN && sec_hit && q.pin) begin
          d.pin = 1'b0;
          set_flag = 1'b1;
          if (mode == ocp_pkg::OCP_MODE_DOUBLE_SHOT) begin
            d.st = ocp_pkg::OCP_ST_DONE;
          end
        end
        // continuous double mode stays in run forever
        if (mode == ocp_pkg::OCP_MODE_DOUBLE_CONT) begin
          d.st = (d.st == ocp_pkg::OCP_ST_DONE) ? ocp_pkg::OCP_ST_RUN : d.st;
        end
      end
      ocp_pkg::OCP_MODE_PWM_EDGE, ocp_pkg::OCP_MODE_PWM_CENTER: begin
        if (q.fault) begin
          d.pin = 1'b0;
        end else if (tick) begin
          // edge active while count below duty, default once duty reached; center active above duty
          if (d.wrap && mode == ocp_pkg::OCP_MODE_PWM_EDGE) begin
            d.pin = (q.primary != 16'h0000);
          end else if (duty_hit) begin
            d.pin = (mode == ocp_pkg::OCP_MODE_PWM_CENTER) ? q.up : 1'b0;
          end
        end
        // flag on the period match: the edge wrap, or the turn at the top
        if ((d.wrap && mode == ocp_pkg::OCP_MODE_PWM_EDGE) || (q.up && !d.up)) begin
          set_flag = 1'b1;
        end
      end
      default: begin
        d.pin = 1'b0;
      end
    endcase

    // register write; a control_one write re-arms the one-shot
    if (wr) begin
      case (idx)
        3'h0: begin
          d.control_one = merge(q.control_one, pwdata_in, pstrb_in,
                                ocp_pkg::OCP_CONTROL_ONE_MASK);
          d.st = ocp_pkg::OCP_ST_RUN;
          // single low idles at the high level until its match
          d.pin = (d.control_one[ocp_pkg::OCP_MODE_LSB +: 3] == ocp_pkg::OCP_MODE_SINGLE_LOW);
          d.fault = 1'b0;
          d.count = 16'h0000;
          d.up = 1'b1;
          d.pri_shadow = q.primary;
          d.sec_shadow = q.secondary;
        end
        3'h1: d.control_two = merge(q.control_two, pwdata_in, pstrb_in,
                                    ocp_pkg::OCP_CONTROL_TWO_MASK);
        3'h2: d.primary = pri_m[15:0];
        3'h3: d.secondary = sec_m[15:0];
        3'h4: begin
          // write one to clear; a match in the same cycle wins
          if (pstrb_in[0] && pwdata_in[ocp_pkg::OCP_FLAG_BIT]) begin
            d.flag = 1'b0;
          end
          if (pstrb_in[0] && pwdata_in[ocp_pkg::OCP_FAULT_BIT]) begin
            d.fault = 1'b0;
          end
        end
        3'h5: ;
        default: ;
      endcase
    end
    if (set_flag) begin
      d.flag = 1'b1;
    end
    // after the write, so a fault in the cycle of its clear still latches
    if (pwm && |(q.flt_s2 & flt_en)) begin
      d.fault = 1'b1;
    end
    // unmapped address: error shown in the ready cycle of either direction
    if (first && idx == 3'h7) begin
      d.slverr = 1'b1;
    end
    // the new mode decides, so a start from off arms the run state
    if (d.control_one[ocp_pkg::OCP_MODE_LSB +: 3] == ocp_pkg::OCP_MODE_OFF) begin
      d.st = ocp_pkg::OCP_ST_IDLE;
      d.count = 16'h0000;
      d.triggered = 1'b0;
    end

    // read data, captured in the access cycle
    if (rd) begin
      case (idx)
        3'h0: d.prdata = q.control_one;
        3'h1: d.prdata = q.control_two;
        3'h2: d.prdata = {16'h0000, q.primary};
        3'h3: d.prdata = {16'h0000, q.secondary};
        3'h4: d.prdata = {28'h0000000, q.st == ocp_pkg::OCP_ST_RUN, q.fault, q.pin, q.flag};
        3'h5: d.prdata = {16'h0000, q.count};
        default: begin
          d.prdata = 32'h0000_0000;
          d.slverr = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.control_two <= ocp_pkg::OCP_CONTROL_TWO_RST;
      q.up <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs; the pin is driven only while tristate is clear
  assign pready_out = psel_in && penable_in && q.prdata_ready;
  assign prdata_out = q.prdata;
  assign pslverr_out = q.slverr;
  assign count_out = q.count;
  assign wrap_out = q.wrap;
  assign compare_output_out = q.pin ^ invert;
  assign compare_output_oe_out = ~tristate;
  assign compare_interrupt_flag_out = q.flag;

endmodule // ocp_unit
`default_nettype wire

//--- verif/ocp_load.sv
// far-side load model: pull-down on the pin plus pulse counters
`timescale 1ns/10ps
`default_nettype none
module ocp_load (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic pin_in, // level the unit drives
  input wire logic oe_in, // unit drives the pin
  output logic level_out, // resolved wire level
  output logic [15:0] rises_out, // rising edges seen
  output logic [15:0] width_out // last high time in cycles
);
  logic prev_r;
  logic [15:0] run_r;
  // a floating pin must not look driven, so the pull-down wins
  assign level_out = oe_in ? pin_in : 1'h0;
  // count edges and measure each high stretch
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prev_r <= 1'h0;
      run_r <= 16'h0;
      rises_out <= 16'h0;
      width_out <= 16'h0;
    end else begin
      prev_r <= level_out;
      run_r <= level_out ? run_r + 16'h1 : 16'h0;
      if (level_out && !prev_r) rises_out <= rises_out + 16'h1;
      if (!level_out && prev_r) width_out <= run_r;
    end
  end
endmodule // ocp_load
`default_nettype wire

//--- verif/ocp_unit_monitor.sv
// concurrent checks on the ports of the output compare unit
`timescale 1ns/10ps
`default_nettype none
module ocp_unit_chk (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // async reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb write
  input wire logic [7:0] paddr_in, // apb address
  input wire logic [31:0] pwdata_in, // apb write data
  input wire logic pready_out, // apb ready
  input wire logic [15:0] count_out, // timebase count
  input wire logic compare_output_out, // pin level
  input wire logic compare_output_oe_out, // pin enable
  input wire logic compare_interrupt_flag_out // match flag
);
  logic wr;
  logic hit;
  logic [31:0] c1_r, c2_r, pr_r, se_r;
  logic [2:0] hit_r;
  logic [1:0] rise_r;
  // completed writes and compare hits; match-to-pin delay is left open
  assign wr = psel_in && penable_in && pready_out && pwrite_in;
  assign hit = (count_out == pr_r[15:0]) || (count_out == se_r[15:0]);
  // register mirrors, hit history, rises since the last mode write
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      c1_r <= 32'h0;
      c2_r <= ocp_pkg::OCP_CONTROL_TWO_RST;
      pr_r <= 32'h0;
      se_r <= 32'h0;
      hit_r <= 3'h0;
      rise_r <= 2'h0;
    end else begin
      if (wr && paddr_in == ocp_pkg::OCP_CONTROL_ONE_OFS) c1_r <= pwdata_in;
      if (wr && paddr_in == ocp_pkg::OCP_CONTROL_TWO_OFS) c2_r <= pwdata_in;
      if (wr && paddr_in == ocp_pkg::OCP_PRIMARY_OFS) pr_r <= pwdata_in;
      if (wr && paddr_in == ocp_pkg::OCP_SECONDARY_OFS) se_r <= pwdata_in;
      hit_r <= {hit_r[1:0], hit};
      if (wr && paddr_in == ocp_pkg::OCP_CONTROL_ONE_OFS) rise_r <= 2'h0;
      else if ($rose(compare_output_out) && rise_r != 2'h3) rise_r <= rise_r + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_flag_stays_set: assert property (compare_interrupt_flag_out && !wr |=>
    compare_interrupt_flag_out) else $error("match flag dropped without a write");
  a_flag_has_match: assert property ($rose(compare_interrupt_flag_out) |->
    hit || (|hit_r)) else $error("match flag rose with no recent match");
  a_pin_has_match: assert property ($changed(compare_output_out) && c1_r[2:0] != 3'h0 &&
    c1_r[2:0] < 3'h6 && !$past(wr) && !$past(wr, 2) |-> hit || (|hit_r))
    else $error("compare pin moved with no recent match");
  a_off_pin_quiet: assert property (c1_r[2:0] == 3'h0 && $past(c1_r[2:0]) == 3'h0 &&
    !$past(wr) && !$past(wr, 2) |-> $stable(compare_output_out))
    else $error("compare pin moved while the unit is off");
  a_single_holds: assert property (c1_r[2:0] == ocp_pkg::OCP_MODE_SINGLE_HIGH &&
    !c2_r[10] && compare_output_out && !wr |=> compare_output_out)
    else $error("single compare output fell again");
  a_one_shot_pulse: assert property (c1_r[2:0] == ocp_pkg::OCP_MODE_DOUBLE_SHOT |->
    rise_r <= 2'h1) else $error("single shot gave a second pulse");
  a_tris_driven: assert property (c2_r[8] && !c2_r[9] && c1_r[2:0] != 3'h0 &&
    !$past(wr) |-> compare_output_oe_out) else $error("cleared tristate left pin floating");
  a_tris_floats: assert property (c2_r[8] && c2_r[9] && !$past(wr) |->
    !compare_output_oe_out) else $error("tristate set but pin driven");
endmodule // ocp_unit_chk
bind ocp_unit ocp_unit_chk u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .count_out(count_out),
  .compare_output_out(compare_output_out), .compare_output_oe_out(compare_output_oe_out),
  .compare_interrupt_flag_out(compare_interrupt_flag_out));
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the output compare and pwm unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, rstn, psel, pen, pwr, pready, perr, err_v, pre_on, oe, pin, flag, lvl;
  logic tmr_a = 1'h0;
  logic [1:0] ph = 2'h0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [2:0] fault;
  logic [15:0] rises, width, r0;
  int n_errors, compares;
  // 25 mhz core clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // prescaler stand-in, a slow square wave only while enabled
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (pre_on) tmr_a <= ph[1];
  end
  ocp_unit uut (.core_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .tmr_a_pre_in(tmr_a),
    .tmr_b_pre_in(1'h0), .ext_clk_in(1'h0), .fault_in(fault), .sync_in(31'h0),
    .peer_count_in(16'h0), .peer_wrap_in(1'h0), .count_out(), .wrap_out(),
    .compare_output_out(pin), .compare_output_oe_out(oe), .compare_interrupt_flag_out(flag));
  ocp_load load (.core_clk_in(clk), .rstn_in(rstn), .pin_in(pin), .oe_in(oe),
    .level_out(lvl), .rises_out(rises), .width_out(width));
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= {4{w}};
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 64);
    rdv = prdata;
    err_v = perr;
    if (n == 64) n_errors++;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(rdv, e);
  endtask
  // park the unit, restart the timebase, then start the mode
  task automatic run(input logic [31:0] c1);
    apb(1'h1, ocp_pkg::OCP_CONTROL_ONE_OFS, 32'h0);
    apb(1'h1, ocp_pkg::OCP_TIMER_OFS, 32'h0);
    apb(1'h1, ocp_pkg::OCP_CONTROL_ONE_OFS, c1);
    r0 = rises;
  endtask
  task automatic rst();
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    apb(1'h1, ocp_pkg::OCP_PRIMARY_OFS, 32'h4);
    apb(1'h1, ocp_pkg::OCP_SECONDARY_OFS, 32'ha);
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the tests take
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rstn = 1'h0;
    psel = 1'h0;
    pen = 1'h0;
    pwr = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pre_on = 1'h0;
    fault = 3'h0;
    n_errors = 0;
    compares = 0;
    rst();
    rchk(ocp_pkg::OCP_CONTROL_ONE_OFS, 32'h0);
    rchk(ocp_pkg::OCP_CONTROL_TWO_OFS, ocp_pkg::OCP_CONTROL_TWO_RST);
    apb(1'h1, ocp_pkg::OCP_CONTROL_ONE_OFS, 32'hffff_fff8);
    rchk(ocp_pkg::OCP_CONTROL_ONE_OFS, 32'h0000_1c78);
    apb(1'h1, ocp_pkg::OCP_CONTROL_TWO_OFS, 32'hffff_ffff);
    rchk(ocp_pkg::OCP_CONTROL_TWO_OFS, ocp_pkg::OCP_CONTROL_TWO_MASK);
    apb(1'h0, 8'h18, 32'h0);
    check(32'(err_v), 32'h1);
    apb(1'h1, ocp_pkg::OCP_CONTROL_TWO_OFS, 32'h1f);
    rchk(ocp_pkg::OCP_PRIMARY_OFS, 32'h4);
    $display("test done: registers");
    // continuous modes with disabled fault pins raised
    fault <= 3'h7;
    for (int m = 3; m < 8; m++) begin
      if (m == 4) continue; // single shot is tested below
      run(32'(m));
      repeat (200) @(posedge clk);
      check(32'(rises - r0 > 16'h2), 32'h1);
    end
    run({29'h0, ocp_pkg::OCP_MODE_PWM_EDGE});
    repeat (200) @(posedge clk);
    check(32'(width >= 16'h3 && width <= 16'h5), 32'h1);
    apb(1'h1, ocp_pkg::OCP_PRIMARY_OFS, 32'h8);
    repeat (200) @(posedge clk);
    check(32'(width >= 16'h7 && width <= 16'h9), 32'h1);
    // edge pwm with the first fault input enabled while the pins are high
    run(32'h0000_0016);
    repeat (50) @(posedge clk);
    check(32'(rises - r0), 32'h0);
    fault <= 3'h0;
    $display("test done: continuous and pwm");
    // single shot, then re-armed by rewriting the mode
    rst();
    check(32'(flag), 32'h0);
    run({29'h0, ocp_pkg::OCP_MODE_DOUBLE_SHOT});
    repeat (200) @(posedge clk);
    check(32'(rises - r0), 32'h1);
    check(32'(flag), 32'h1);
    apb(1'h1, ocp_pkg::OCP_CONTROL_ONE_OFS, {29'h0, ocp_pkg::OCP_MODE_DOUBLE_SHOT});
    repeat (200) @(posedge clk);
    check(32'(rises - r0), 32'h2);
    check(32'(flag), 32'h1);
    apb(1'h1, ocp_pkg::OCP_STATUS_OFS, 32'h1);
    check(32'(flag), 32'h0);
    run({29'h0, ocp_pkg::OCP_MODE_SINGLE_HIGH});
    repeat (200) @(posedge clk);
    check(32'(lvl), 32'h1);
    run({29'h0, ocp_pkg::OCP_MODE_SINGLE_LOW});
    check(32'(lvl), 32'h1);
    repeat (200) @(posedge clk);
    check(32'(lvl), 32'h0);
    $display("test done: single shot");
    // cascade bit with tristate set then cleared
    run({29'h0, ocp_pkg::OCP_MODE_PWM_EDGE});
    apb(1'h1, ocp_pkg::OCP_CONTROL_TWO_OFS, 32'h31f);
    repeat (4) @(posedge clk);
    check(32'(oe), 32'h0);
    apb(1'h1, ocp_pkg::OCP_CONTROL_TWO_OFS, 32'h11f);
    repeat (4) @(posedge clk);
    check(32'(oe), 32'h1);
    apb(1'h1, ocp_pkg::OCP_CONTROL_TWO_OFS, 32'h1f);
    $display("test done: tristate");
    // timer source: no prescaler pulses, no progress
    run({19'h0, ocp_pkg::OCP_CLK_TIMER_A, 10'h6});
    repeat (200) @(posedge clk);
    check(32'(rises - r0), 32'h0);
    pre_on <= 1'h1;
    repeat (600) @(posedge clk);
    check(32'(rises - r0 > 16'h2), 32'h1);
    $display("test done: clock source");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
